// >>> verilog/slave_evt_pkg.sv
// Purpose: constants and types for the slave task and event register bank
// Assumes: 32-bit AXI4-Lite register bus, byte addresses as printed
// Notes:   channel index field is four bits wide, enable bit is bit 31
package slave_evt_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [11:0] OFF_STOP_TRIG     = 12'h014;
  localparam logic [11:0] OFF_SUSPEND_TRIG  = 12'h01C;
  localparam logic [11:0] OFF_RESUME_TRIG   = 12'h020;
  localparam logic [11:0] OFF_PREP_RX_TRIG  = 12'h030;
  localparam logic [11:0] OFF_PREP_TX_TRIG  = 12'h034;
  localparam logic [11:0] OFF_SUB_STOP      = 12'h094;
  localparam logic [11:0] OFF_SUB_SUSPEND   = 12'h09C;
  localparam logic [11:0] OFF_SUB_RESUME    = 12'h0A0;
  localparam logic [11:0] OFF_SUB_PREP_RX   = 12'h0B0;
  localparam logic [11:0] OFF_SUB_PREP_TX   = 12'h0B4;
  localparam logic [11:0] OFF_EVT_STOPPED   = 12'h104;
  localparam logic [11:0] OFF_EVT_ERROR     = 12'h124;
  localparam logic [11:0] OFF_EVT_RX_START  = 12'h14C;
  localparam logic [11:0] OFF_EVT_TX_START  = 12'h150;
  localparam logic [11:0] OFF_EVT_WRITE     = 12'h164;
  localparam logic [11:0] OFF_EVT_READ      = 12'h168;
  localparam logic [11:0] OFF_PUB_STOPPED   = 12'h184;
  localparam logic [11:0] OFF_PUB_ERROR     = 12'h1A4;
  localparam logic [11:0] OFF_PUB_RX_START  = 12'h1CC;
  localparam logic [11:0] OFF_PUB_TX_START  = 12'h1D0;
  localparam logic [11:0] OFF_PUB_WRITE     = 12'h1E4;
  localparam logic [11:0] OFF_PUB_READ      = 12'h1E8;
  localparam logic [11:0] OFF_SHORTCUTS     = 12'h200;
  localparam logic [11:0] OFF_IRQ_STATUS    = 12'h600;
  localparam logic [11:0] OFF_IRQ_MASK      = 12'h604;

  // ****************************************************************
  // Field layout and reset values
  // ****************************************************************
  localparam int          NUM_TASKS    = 5;
  localparam int          NUM_EVENTS   = 6;
  localparam int          CH_BITS      = 4;
  localparam int          NUM_CH       = 16;
  localparam int          EN_BIT       = 31;
  localparam int          SC_WRITE_BIT = 0;
  localparam int          SC_READ_BIT  = 1;
  localparam logic [31:0] CFG_RESET    = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // Task order: stop, suspend, resume, prepare receive, prepare transmit
  localparam int T_STOP = 0;
  localparam int T_SUSP = 1;
  localparam int T_RES  = 2;
  localparam int T_PRX  = 3;
  localparam int T_PTX  = 4;
  // Event order: stopped, error, rx started, tx started, write, read
  localparam int E_WRITE = 4;
  localparam int E_READ  = 5;

  // One subscribe or publish configuration
  typedef struct packed {
    logic               en;
    logic [CH_BITS-1:0] channel_index;
  } chan_cfg_t;

  // AXI4-Lite write request
  typedef struct packed {
    logic        awvalid;
    logic [11:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
  } axil_wr_t;

  // AXI4-Lite read request
  typedef struct packed {
    logic        arvalid;
    logic [11:0] araddr;
    logic        rready;
  } axil_rd_t;

endpackage : slave_evt_pkg

// >>> verilog/slave_evt_regs.sv
// Purpose: task, event, subscribe, publish and shortcut register bank
// Assumes: one clock, synchronous active-high reset, clock enable
// Notes:   task strobes and event publishing are one-cycle pulses
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none

// Function
// - Writing 1 to prepare-transmit trigger arms slave to answer next read.
// - Each task has a subscribe register whose channel index picks its channel.
// - Subscribe enable bit 31 set lets the channel trigger; clear ignores it.
// - Each event has a publish register naming the channel it drives.
// - Publish enable bit 31 set drives the event; clear suppresses it.
// - Shortcut bit 0 set makes the write event trigger suspend.
// - Shortcut bit 1 set makes the read event trigger suspend.
module slave_evt_regs
  import slave_evt_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  clk_en_i,
  // AXI4-Lite slave
  input  wire axil_wr_t              wr_req_i,
  input  wire axil_rd_t              rd_req_i,
  output logic                       awready_o,
  output logic                       wready_o,
  output logic                       bvalid_o,
  output logic [1:0]                 bresp_o,
  output logic                       arready_o,
  output logic                       rvalid_o,
  output logic [31:0]                rdata_o,
  output logic [1:0]                 rresp_o,
  // Event channel interconnect
  input  wire logic [NUM_CH-1:0]     chan_in_i,
  output logic [NUM_CH-1:0]          chan_out_o,
  // Protocol engine side
  input  wire logic [NUM_EVENTS-1:0] engine_evt_i,
  output logic [NUM_TASKS-1:0]       task_o,
  output logic                       irq_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  // All state in one struct: reset and freeze reach every bit
  typedef struct packed {
    logic                          aw_held;
    logic [11:0]                   aw_addr;
    logic                          w_held;
    logic [31:0]                   w_data;
    logic [3:0]                    w_strb;
    logic                          bvalid;
    logic [1:0]                    bresp;
    logic                          rvalid;
    logic [31:0]                   rdata;
    logic [1:0]                    rresp;
    chan_cfg_t [NUM_TASKS-1:0]     sub;
    chan_cfg_t [NUM_EVENTS-1:0]    pub;
    logic [1:0]                    shortcuts;
    logic [NUM_EVENTS-1:0]         flags;
    logic [NUM_EVENTS-1:0]         mask;
    logic [NUM_EVENTS-1:0]         irq_stat;
    logic [NUM_TASKS-1:0]          task_q;
    logic [NUM_CH-1:0]             chan_out;
    logic                          irq;
  } state_t;

  state_t st;
  state_t next_st;

  // Offsets indexed by task and event position
  localparam logic [11:0] TRIG_OFF [NUM_TASKS] = '{OFF_STOP_TRIG,
    OFF_SUSPEND_TRIG, OFF_RESUME_TRIG, OFF_PREP_RX_TRIG, OFF_PREP_TX_TRIG};
  localparam logic [11:0] SUB_OFF [NUM_TASKS] = '{OFF_SUB_STOP,
    OFF_SUB_SUSPEND, OFF_SUB_RESUME, OFF_SUB_PREP_RX, OFF_SUB_PREP_TX};
  localparam logic [11:0] EVT_OFF [NUM_EVENTS] = '{OFF_EVT_STOPPED,
    OFF_EVT_ERROR, OFF_EVT_RX_START, OFF_EVT_TX_START, OFF_EVT_WRITE,
    OFF_EVT_READ};
  localparam logic [11:0] PUB_OFF [NUM_EVENTS] = '{OFF_PUB_STOPPED,
    OFF_PUB_ERROR, OFF_PUB_RX_START, OFF_PUB_TX_START, OFF_PUB_WRITE,
    OFF_PUB_READ};

  // ****************************************************************
  // Combinational helpers
  // ****************************************************************
  logic                   wr_fire;
  logic                   wr_hit;
  logic                   wr_all;
  logic [31:0]            rd_val;
  logic                   rd_hit;
  logic [11:0]            rd_addr;
  logic [NUM_TASKS-1:0]   sw_task;
  logic [NUM_TASKS-1:0]   chan_task;
  logic [NUM_EVENTS-1:0]  evt_clr;
  logic [NUM_EVENTS-1:0]  st_clr;

  // Write commits once address and data are both held
  assign wr_fire = st.aw_held && st.w_held && !st.bvalid;
  // Subscribe and publish registers only update on full-word writes, keeps fields coherent
  assign wr_all  = (st.w_strb == 4'hF);
  // Byte lane bits ignored on reads as on writes
  assign rd_addr = {rd_req_i.araddr[11:2], 2'b00};

  // Channel lines share this clock, so no synchroniser is needed
  // Per-task trigger sources: register write or subscribed channel
  for (genvar t = 0; t < NUM_TASKS; t++) begin : g_task
    assign sw_task[t]   = wr_fire && st.aw_addr == TRIG_OFF[t]
                          && st.w_strb[0] && st.w_data[0];
    assign chan_task[t] = st.sub[t].en
                          && chan_in_i[st.sub[t].channel_index];
  end

  // Per-event clear: flag on a written zero, interrupt status on a written one
  for (genvar e = 0; e < NUM_EVENTS; e++) begin : g_evt
    assign evt_clr[e] = wr_fire && st.aw_addr == EVT_OFF[e]
                        && st.w_strb[0] && !st.w_data[0];
    assign st_clr[e]  = wr_fire && st.aw_addr == OFF_IRQ_STATUS
                        && st.w_strb[0] && st.w_data[e];
  end

  // Read decode
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b0;
    for (int i = 0; i < NUM_TASKS; i++) begin
      if (rd_addr == SUB_OFF[i]) begin
        rd_val[EN_BIT]      = st.sub[i].en;
        rd_val[CH_BITS-1:0] = st.sub[i].channel_index;
        rd_hit              = 1'b1;
      end else if (rd_addr == TRIG_OFF[i]) begin
        rd_hit = 1'b1;
      end
    end
    for (int i = 0; i < NUM_EVENTS; i++) begin
      if (rd_addr == EVT_OFF[i]) begin
        rd_val[0] = st.flags[i];
        rd_hit    = 1'b1;
      end else if (rd_addr == PUB_OFF[i]) begin
        rd_val[EN_BIT]      = st.pub[i].en;
        rd_val[CH_BITS-1:0] = st.pub[i].channel_index;
        rd_hit              = 1'b1;
      end
    end
    if (rd_addr == OFF_SHORTCUTS) begin
      rd_val[1:0] = st.shortcuts;
      rd_hit      = 1'b1;
    end else if (rd_addr == OFF_IRQ_STATUS) begin
      rd_val[NUM_EVENTS-1:0] = st.irq_stat;
      rd_hit                 = 1'b1;
    end else if (rd_addr == OFF_IRQ_MASK) begin
      rd_val[NUM_EVENTS-1:0] = st.mask;
      rd_hit                 = 1'b1;
    end
  end

  // Write decode hit flag
  always_comb begin
    wr_hit = 1'b0;
    for (int i = 0; i < NUM_TASKS; i++) begin
      if (st.aw_addr == TRIG_OFF[i] || st.aw_addr == SUB_OFF[i]) begin
        wr_hit = 1'b1;
      end
    end
    for (int i = 0; i < NUM_EVENTS; i++) begin
      if (st.aw_addr == EVT_OFF[i] || st.aw_addr == PUB_OFF[i]) begin
        wr_hit = 1'b1;
      end
    end
    if (st.aw_addr == OFF_SHORTCUTS || st.aw_addr == OFF_IRQ_STATUS
        || st.aw_addr == OFF_IRQ_MASK) begin
      wr_hit = 1'b1;
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic [NUM_TASKS-1:0] tasks;
    next_st = st;
    tasks   = sw_task | chan_task;

    // Write address and data channels, either order
    if (wr_req_i.awvalid && !st.aw_held) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = {wr_req_i.awaddr[11:2], 2'b00};
    end
    if (wr_req_i.wvalid && !st.w_held) begin
      next_st.w_held = 1'b1;
      next_st.w_data = wr_req_i.wdata;
      next_st.w_strb = wr_req_i.wstrb;
    end
    if (st.bvalid && wr_req_i.bready) begin
      next_st.bvalid = 1'b0;
    end
    // Commit: answer and register update in the same cycle
    if (wr_fire) begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
      // Partial writes to a subscribe or publish register are answered but dropped
      for (int i = 0; i < NUM_TASKS; i++) begin
        if (wr_all && st.aw_addr == SUB_OFF[i]) begin
          next_st.sub[i].en            = st.w_data[EN_BIT];
          next_st.sub[i].channel_index = st.w_data[CH_BITS-1:0];
        end
      end
      for (int i = 0; i < NUM_EVENTS; i++) begin
        if (wr_all && st.aw_addr == PUB_OFF[i]) begin
          next_st.pub[i].en            = st.w_data[EN_BIT];
          next_st.pub[i].channel_index = st.w_data[CH_BITS-1:0];
        end
      end
      if (st.aw_addr == OFF_SHORTCUTS && st.w_strb[0]) begin
        next_st.shortcuts = st.w_data[1:0];
      end
      if (st.aw_addr == OFF_IRQ_MASK && st.w_strb[0]) begin
        next_st.mask = st.w_data[NUM_EVENTS-1:0];
      end
    end

    // Read channel: one outstanding read
    // A new address is taken only once the last answer has gone
    if (st.rvalid && rd_req_i.rready) begin
      next_st.rvalid = 1'b0;
    end
    if (rd_req_i.arvalid && !st.rvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd_val;
      next_st.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end

    // Shortcuts fire suspend straight from engine events
    if (st.shortcuts[SC_WRITE_BIT] && engine_evt_i[E_WRITE]) begin
      tasks[T_SUSP] = 1'b1;
    end
    if (st.shortcuts[SC_READ_BIT] && engine_evt_i[E_READ]) begin
      tasks[T_SUSP] = 1'b1;
    end
    next_st.task_q = tasks;

    // Event flags: a new event wins over a clear in the same cycle
    // Interrupt follows the next status so it rises with the flag
    next_st.flags    = (st.flags & ~evt_clr) | engine_evt_i;
    next_st.irq_stat = (st.irq_stat & ~st_clr) | engine_evt_i;
    next_st.irq      = |(next_st.irq_stat & next_st.mask);

    // Publish each event onto its chosen channel
    // Two events on one channel merge into a single pulse
    next_st.chan_out = '0;
    for (int i = 0; i < NUM_EVENTS; i++) begin
      if (st.pub[i].en && engine_evt_i[i]) begin
        next_st.chan_out[st.pub[i].channel_index] = 1'b1;
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Clock enable low holds every field, strobes included
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else if (clk_en_i) begin
      st <= next_st;
    end
  end

  // Outputs straight from flops; resume is software's job after suspend
  // Ready outputs are the inverse of a held flag
  assign awready_o  = !st.aw_held;
  assign wready_o   = !st.w_held;
  assign bvalid_o   = st.bvalid;
  assign bresp_o    = st.bresp;
  assign arready_o  = !st.rvalid;
  assign rvalid_o   = st.rvalid;
  assign rdata_o    = st.rdata;
  assign rresp_o    = st.rresp;
  assign chan_out_o = st.chan_out;
  assign task_o     = st.task_q;
  assign irq_o      = st.irq;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // Software trigger of prepare transmit pulses its strobe
  a_prep_tx_task: assert property (
    clk_en_i && sw_task[T_PTX] |=> task_o[T_PTX])
    else $error("prepare transmit not pulsed");
  // A zero written to the trigger starts nothing
  a_trig_zero: assert property (
    clk_en_i && wr_fire && st.aw_addr == OFF_PREP_TX_TRIG
    && !st.w_data[0] && !chan_task[T_PTX] |=> !task_o[T_PTX])
    else $error("prepare transmit on zero write");
  // Strobes last one cycle unless triggered again
  a_task_single: assert property (
    clk_en_i && task_o[T_PTX] && !sw_task[T_PTX] && !chan_task[T_PTX]
    |=> !task_o[T_PTX]) else $error("prepare transmit strobe stuck");
  // Disabled subscription leaves its task alone
  a_sub_gate_off: assert property (
    clk_en_i && !st.sub[T_STOP].en && !sw_task[T_STOP]
    |=> !task_o[T_STOP])
    else $error("disabled subscription triggered stop");
  // Enabled subscription triggers its task from its channel
  a_sub_trigger: assert property (
    clk_en_i && st.sub[T_RES].en
    && chan_in_i[st.sub[T_RES].channel_index] |=> task_o[T_RES])
    else $error("subscribed channel did not trigger resume");
  a_sub_ptx: assert property (
    clk_en_i && st.sub[T_PTX].en
    && chan_in_i[st.sub[T_PTX].channel_index] |=> task_o[T_PTX])
    else $error("subscribed channel did not prepare transmit");
  // Published events land on the channel chosen a cycle before
  a_pub_drive: assert property (
    clk_en_i && st.pub[0].en && engine_evt_i[0]
    |=> chan_out_o[$past(st.pub[0].channel_index)])
    else $error("stopped event not published");
  a_pub_write: assert property (
    clk_en_i && st.pub[E_WRITE].en && engine_evt_i[E_WRITE]
    |=> chan_out_o[$past(st.pub[E_WRITE].channel_index)])
    else $error("write event not published");
  // No event, or a suppressed one, drives no channel
  a_pub_quiet: assert property (
    clk_en_i && engine_evt_i == '0 |=> chan_out_o == '0)
    else $error("channel driven without event");
  a_pub_gate_off: assert property (
    clk_en_i && !st.pub[0].en && engine_evt_i[0]
    && engine_evt_i[NUM_EVENTS-1:1] == '0 |=> chan_out_o == '0)
    else $error("suppressed event published");
  // Shortcuts turn write or read into suspend
  a_short_write: assert property (
    clk_en_i && st.shortcuts[SC_WRITE_BIT] && engine_evt_i[E_WRITE]
    |=> task_o[T_SUSP]) else $error("write shortcut missed");
  a_short_read: assert property (
    clk_en_i && st.shortcuts[SC_READ_BIT] && engine_evt_i[E_READ]
    |=> task_o[T_SUSP]) else $error("read shortcut missed");
  // With both shortcuts clear only software or a channel suspends
  a_short_off: assert property (
    clk_en_i && st.shortcuts == 2'b00 && !sw_task[T_SUSP]
    && !chan_task[T_SUSP] |=> !task_o[T_SUSP])
    else $error("suspend without a source");
  // Flags stick until a zero is written; a new event wins
  a_flag_sticky: assert property (
    clk_en_i && engine_evt_i[E_READ]
    ##1 (!clk_en_i || !evt_clr[E_READ])[*2] |=> st.flags[E_READ])
    else $error("read flag lost");
  a_flag_set: assert property (
    clk_en_i && engine_evt_i[0] |=> st.flags[0])
    else $error("stopped flag not set");
  a_flag_clear: assert property (
    clk_en_i && evt_clr[E_WRITE] && !engine_evt_i[E_WRITE]
    |=> !st.flags[E_WRITE]) else $error("write flag not cleared");

  // ****************************************************************
  // Cover points
  // ****************************************************************
  c_short_read: cover property (st.shortcuts[1] && engine_evt_i[E_READ]);
  c_sub_task:   cover property (|chan_task);
  c_flag_clear: cover property (|evt_clr ##1 rvalid_o);
  c_pub_event:  cover property (|chan_out_o);
  c_irq_raise:  cover property (!irq_o ##1 irq_o);

endmodule : slave_evt_regs

`default_nettype wire

// >>> tb/evt_peer.sv
// Purpose: far side model, engine events and channel pulses
// Assumes: same clock as the register bank
// Notes:   counts task and publish pulses for the bench
`timescale 1ns/1ns
`default_nettype none
module evt_peer
  import slave_evt_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Bank outputs
  input  wire logic [NUM_TASKS-1:0]  task_i,
  input  wire logic [NUM_CH-1:0]     chan_i,
  // Drives into the bank
  output logic [NUM_EVENTS-1:0]      evt_o,
  output logic [NUM_CH-1:0]          chan_o
);
  int task_cnt [NUM_TASKS];
  int chan_cnt [NUM_CH];

  initial begin
    evt_o = '0;
    chan_o = '0;
  end

  // Mid-cycle sampling; one-cycle strobes count once each
  always @(negedge clk_i) begin
    for (int i = 0; i < NUM_TASKS; i++) begin
      if (!rst_i && task_i[i] === 1'b1) task_cnt[i]++;
    end
    for (int i = 0; i < NUM_CH; i++) begin
      if (!rst_i && chan_i[i] === 1'b1) chan_cnt[i]++;
    end
  end

  // One-cycle pulse on an event or a channel line
  task automatic pulse(input bit is_evt, input int idx);
    @(posedge clk_i);
    if (is_evt) evt_o[idx] <= 1'b1;
    else chan_o[idx] <= 1'b1;
    @(posedge clk_i);
    evt_o <= '0;
    chan_o <= '0;
  endtask
endmodule // evt_peer
`default_nettype wire

// >>> tb/tb_top.sv
// Purpose: register bank bench over AXI4-Lite
// Assumes: answers awaited, never counted in cycles
// Notes:   handshakes judged at the falling edge before
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import slave_evt_pkg::*;
;
  localparam logic [11:0] TRG [5] = '{OFF_STOP_TRIG, OFF_SUSPEND_TRIG,
    OFF_RESUME_TRIG, OFF_PREP_RX_TRIG, OFF_PREP_TX_TRIG};
  localparam logic [11:0] SUB [5] = '{OFF_SUB_STOP, OFF_SUB_SUSPEND,
    OFF_SUB_RESUME, OFF_SUB_PREP_RX, OFF_SUB_PREP_TX};
  localparam logic [11:0] EVF [6] = '{OFF_EVT_STOPPED, OFF_EVT_ERROR,
    OFF_EVT_RX_START, OFF_EVT_TX_START, OFF_EVT_WRITE, OFF_EVT_READ};
  localparam logic [11:0] PUB [6] = '{OFF_PUB_STOPPED, OFF_PUB_ERROR,
    OFF_PUB_RX_START, OFF_PUB_TX_START, OFF_PUB_WRITE, OFF_PUB_READ};
  logic core_clk_i, rst_i, awready, wready, bvalid, arready, rvalid, irq;
  logic clk_en;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd_v;
  logic [NUM_CH-1:0] chan_in, chan_out;
  logic [NUM_EVENTS-1:0] evt;
  logic [NUM_TASKS-1:0] tsk;
  axil_wr_t wr_q;
  axil_rd_t rd_q;
  int mismatches, n_checks;
  int exp_task [NUM_TASKS];
  int exp_chan [NUM_CH];

  slave_evt_regs dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .clk_en_i(clk_en), .wr_req_i(wr_q), .rd_req_i(rd_q),
    .awready_o(awready), .wready_o(wready), .bvalid_o(bvalid),
    .bresp_o(bresp), .arready_o(arready), .rvalid_o(rvalid),
    .rdata_o(rdata), .rresp_o(rresp), .chan_in_i(chan_in),
    .chan_out_o(chan_out), .engine_evt_i(evt), .task_o(tsk),
    .irq_o(irq));
  evt_peer peer (.clk_i(core_clk_i), .rst_i(rst_i), .task_i(tsk),
    .chan_i(chan_out), .evt_o(evt), .chan_o(chan_in));

  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  // ****************************************************************
  // Bus and compare tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Both halves offered together; each released once taken
  task automatic axw(input logic [11:0] a, input logic [31:0] d);
    bit pa, pw, ta, tw, tb;
    pa = 1;
    pw = 1;
    @(posedge core_clk_i);
    wr_q <= '{1'b1, a, 1'b1, d, 4'hF, 1'b1};
    forever begin
      @(negedge core_clk_i);
      ta = pa && awready;
      tw = pw && wready;
      tb = bvalid;
      rsp = bresp;
      @(posedge core_clk_i);
      if (ta) wr_q.awvalid <= 1'b0;
      if (ta) pa = 0;
      if (tw) wr_q.wvalid <= 1'b0;
      if (tw) pw = 0;
      if (tb) wr_q.bready <= 1'b0;
      if (tb) break;
    end
  endtask

  task automatic chk_rd(input logic [11:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    bit pa, ta, tv;
    pa = 1;
    @(posedge core_clk_i);
    rd_q <= '{1'b1, a, 1'b1};
    forever begin
      @(negedge core_clk_i);
      ta = pa && arready;
      tv = rvalid;
      rd_v = rdata;
      rsp = rresp;
      @(posedge core_clk_i);
      if (ta) rd_q.arvalid <= 1'b0;
      if (ta) pa = 0;
      if (tv) rd_q.rready <= 1'b0;
      if (tv) break;
    end
    chk(rd_v, e);
    chk({30'h0, rsp}, {30'h0, er});
  endtask

  task automatic wr_ok(input logic [11:0] a, input logic [31:0] d);
    axw(a, d);
    chk({30'h0, rsp}, {30'h0, RESP_OKAY});
  endtask

  // Pulse counts after the strobes have settled
  task automatic cnts();
    repeat (4) @(posedge core_clk_i);
    for (int i = 0; i < NUM_TASKS; i++) chk(peer.task_cnt[i], exp_task[i]);
    for (int i = 0; i < NUM_CH; i++) chk(peer.chan_cnt[i], exp_chan[i]);
  endtask

  task automatic chk_irq(input logic e);
    repeat (3) @(negedge core_clk_i);
    chk({31'h0, irq}, {31'h0, e});
  endtask

  task automatic wrap_up();
    if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge core_clk_i);
    mismatches++;
    wrap_up();
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    rst_i = 1'b1;
    clk_en = 1'b1;
    wr_q = '0;
    rd_q = '0;
    repeat (10) @(posedge core_clk_i);
    rst_i <= 1'b0;
    // Reset values, then an unmapped place
    for (int i = 0; i < 6; i++) chk_rd(EVF[i], CFG_RESET, RESP_OKAY);
    for (int i = 0; i < 6; i++) chk_rd(PUB[i], CFG_RESET, RESP_OKAY);
    for (int i = 0; i < 5; i++) chk_rd(SUB[i], CFG_RESET, RESP_OKAY);
    chk_rd(OFF_SHORTCUTS, CFG_RESET, RESP_OKAY);
    axw(12'h7F0, 32'h1);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    chk_rd(12'h7F0, 32'h0, RESP_SLVERR);
    // Software triggers, prepare transmit among them
    for (int t = 0; t < 5; t++) begin
      wr_ok(TRG[t], 32'h1);
      exp_task[t]++;
      chk_rd(TRG[t], 32'h0, RESP_OKAY);
    end
    wr_ok(OFF_PREP_TX_TRIG, 32'h0);
    cnts();
    // Subscriptions: own channel only, and only while enabled
    for (int t = 0; t < 5; t++) begin
      wr_ok(SUB[t], 32'h8000_0000 | 32'(t + 2));
      chk_rd(SUB[t], 32'h8000_0000 | 32'(t + 2), RESP_OKAY);
      peer.pulse(1'b0, t + 3);
      peer.pulse(1'b0, t + 2);
      exp_task[t]++;
      cnts();
      wr_ok(SUB[t], 32'(t + 2));
      peer.pulse(1'b0, t + 2);
      cnts();
    end
    // Publishing and flags; shortcuts still clear
    for (int e = 0; e < 6; e++) begin
      wr_ok(PUB[e], 32'h8000_0000 | 32'(e + 8));
      peer.pulse(1'b1, e);
      exp_chan[e + 8]++;
      cnts();
      wr_ok(EVF[e], 32'h1);
      chk_rd(EVF[e], 32'h1, RESP_OKAY);
      wr_ok(EVF[e], 32'h0);
      chk_rd(EVF[e], 32'h0, RESP_OKAY);
      wr_ok(PUB[e], 32'(e + 8));
      peer.pulse(1'b1, e);
      cnts();
    end
    // Each shortcut alone
    wr_ok(OFF_SHORTCUTS, 32'h1);
    chk_rd(OFF_SHORTCUTS, 32'h1, RESP_OKAY);
    peer.pulse(1'b1, E_WRITE);
    peer.pulse(1'b1, E_READ);
    exp_task[T_SUSP]++;
    cnts();
    wr_ok(OFF_SHORTCUTS, 32'h2);
    peer.pulse(1'b1, E_READ);
    peer.pulse(1'b1, E_WRITE);
    exp_task[T_SUSP]++;
    cnts();
    // Software resumes after preparing the answer
    wr_ok(OFF_RESUME_TRIG, 32'h1);
    exp_task[T_RES]++;
    cnts();
    // Interrupt: raised, cleared, masked
    wr_ok(OFF_IRQ_MASK, 32'h20);
    chk_irq(1'b1);
    wr_ok(OFF_IRQ_STATUS, 32'h3F);
    chk_irq(1'b0);
    peer.pulse(1'b1, E_WRITE);
    chk_irq(1'b0);
    chk_rd(OFF_IRQ_STATUS, 32'h10, RESP_OKAY);
    peer.pulse(1'b1, E_READ);
    exp_task[T_SUSP]++;
    chk_irq(1'b1);
    wr_ok(OFF_IRQ_STATUS, 32'h20);
    chk_irq(1'b0);
    cnts();
    // Frozen clock enable: an event in that time is lost
    @(posedge core_clk_i);
    clk_en <= 1'b0;
    peer.pulse(1'b1, E_READ);
    @(posedge core_clk_i);
    clk_en <= 1'b1;
    cnts();
    chk_rd(OFF_IRQ_STATUS, 32'h10, RESP_OKAY);
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
